// ===== design/src_top.sv
// system reset controller: merges five reset sources into the core reset
// assumes detectors, pin and test port are asynchronous; watchdog and fuses
// are on clk_i
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - reset loads I/O, release fetches reset vector
// - I/O forced at once, no clock needed
// - hold reset until delay counter completes
// - delay length chosen by clock-select fuses
// - any of five sources asserts reset
// - supply-up active while supply is low
// - pin source after low beyond minimum width
// - watchdog source needs enable and time-out
// - brown-out source needs enable and low supply
// - test-port source follows its register bit
// - supply rise starts the delay counter
// - supply drop reasserts reset without delay
// - watchdog is one-cycle pulse, count after
// - cause flags; supply-up or zero-write clears
module src_top import src_pkg::*; #(
	parameter int TOUT_BASE_CYC = TOUT_BASE_CYC_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// analogue detectors and pins
	input wire logic supply_low_i,
	input wire logic reset_pin_n_i,
	input wire logic bod_enable_i,
	input wire logic bod_low_i,
	input wire logic testport_rst_i,
	// watchdog
	input wire logic wdt_enable_i,
	input wire logic wdt_timeout_i,
	// fuses
	input wire logic [FUSE_W-1:0] clock_select_fuses_i,
	// reset_cause_register access
	input wire logic cause_wr_i,
	input wire src_flags_t cause_wdata_i,
	output src_flags_t reset_cause_o,
	// resets out
	output logic io_reset_o,
	output logic core_reset_o,
	output logic vector_fetch_o,
	output src_flags_t src_active_o
);

	logic [SYNC_W-1:0] lvl_s;
	logic pin_hit;
	logic wdt_tmo_ff;
	logic wdt_src;
	src_flags_t src_now;
	logic src_any;
	src_state_t state_ff;
	src_state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] delay_ff;
	logic [CNT_W-1:0] nxt_delay;
	logic core_reset_ff;
	logic vec_ff;
	src_flags_t cause_ff;
	src_flags_t nxt_cause;

	// input conditioning; pin is inverted so every lane is active high
	src_sync3 #(
		.W(SYNC_W),
		.RST_VAL(SYNC_RST_VAL)
	) u_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.async_i({testport_rst_i, bod_low_i, ~reset_pin_n_i, supply_low_i}),
		.sync_o(lvl_s)
	);

	// short pin glitches never reach the core
	src_persist #(
		.N(RST_MIN_CYC)
	) u_pin_width (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.lvl_i(lvl_s[LANE_PIN]),
		.hit_o(pin_hit)
	);

	// watchdog time-out counts once per rising edge, even if held
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wdt_tmo_ff <= 1'b0;
		end else begin
			wdt_tmo_ff <= wdt_timeout_i;
		end
	end

	assign wdt_src = wdt_enable_i && wdt_timeout_i && !wdt_tmo_ff;

	always_comb begin
		src_now.supply_up = lvl_s[LANE_SUPPLY];
		src_now.pin = pin_hit;
		src_now.brownout = bod_enable_i && lvl_s[LANE_BOD];
		src_now.watchdog = wdt_src;
		src_now.testport = lvl_s[LANE_TP];
	end

	assign src_any = |src_now;
	assign src_active_o = src_now;

	// raw levels, so ports reset even with no clock running
	// synced term keeps ports reset once a short raw pulse has gone
	assign io_reset_o = supply_low_i || !reset_pin_n_i ||
		(bod_enable_i && bod_low_i) || testport_rst_i ||
		wdt_src || src_any || core_reset_ff;

	// sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SRC_HOLD: begin
				if (!src_any) begin
					nxt_state = SRC_STRETCH;
				end
			end
			SRC_STRETCH: begin
				if (src_any) begin
					nxt_state = SRC_HOLD;
				end else if (cnt_ff == delay_ff - 1'b1) begin
					nxt_state = SRC_RUN;
				end
			end
			SRC_RUN: begin
				if (src_any) begin
					nxt_state = SRC_HOLD;
				end
			end
			default: begin
				nxt_state = SRC_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state_ff <= SRC_HOLD;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// delay counter; any source cuts it back to zero
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_ff <= '0;
		end else if (state_ff == SRC_STRETCH && !src_any) begin
			cnt_ff <= cnt_ff + 1'b1;
		end else begin
			cnt_ff <= '0;
		end
	end

	// fuses sampled only while held, so a count never changes length midway
	assign nxt_delay = CNT_W'(TOUT_BASE_CYC) << clock_select_fuses_i;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			delay_ff <= CNT_W'(TOUT_BASE_CYC);
		end else if (state_ff == SRC_HOLD) begin
			delay_ff <= nxt_delay;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			core_reset_ff <= 1'b1;
		end else begin
			core_reset_ff <= (nxt_state != SRC_RUN);
		end
	end

	// the live source term removes the register's cycle on a supply drop
	assign core_reset_o = core_reset_ff || src_any;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			vec_ff <= 1'b0;
		end else begin
			vec_ff <= (state_ff == SRC_STRETCH) && (nxt_state == SRC_RUN);
		end
	end

	assign vector_fetch_o = vec_ff;

	// cause flags: sources set; zero-write clears; supply-up clears the rest
	always_comb begin
		nxt_cause = cause_ff;
		if (cause_wr_i) begin
			nxt_cause = cause_ff & cause_wdata_i;
		end
		if (src_now.supply_up) begin
			nxt_cause = FLAGS_RST;
			nxt_cause.supply_up = 1'b1;
		end else begin
			nxt_cause = nxt_cause | src_now;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cause_ff <= FLAGS_RST;
		end else begin
			cause_ff <= nxt_cause;
		end
	end

	assign reset_cause_o = cause_ff;

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_release;
		$fell(core_reset_ff);
	endsequence

	sequence s_supply_drop;
		(state_ff == SRC_RUN) ##1 src_now.supply_up;
	endsequence

	sequence s_wdt_fall;
		wdt_src ##1 !src_any;
	endsequence

	sequence s_restart;
		(state_ff == SRC_STRETCH) && (cnt_ff != '0) ##0 src_any;
	endsequence

	a_io_forced:
	assert property ((supply_low_i || !reset_pin_n_i || testport_rst_i)
		|-> io_reset_o)
		else $error("io reset not forced by raw source");

	a_src_holds:
	assert property (src_any |-> core_reset_o && nxt_state == SRC_HOLD ##1
		state_ff == SRC_HOLD && core_reset_ff)
		else $error("core reset not held by active source");

	a_full_stretch:
	assert property (s_release |-> $past(state_ff) == SRC_STRETCH &&
		$past(cnt_ff) == delay_ff - 1'b1)
		else $error("reset released before full delay");

	a_fuse_delay:
	assert property ((state_ff == SRC_HOLD) |=>
		delay_ff == (CNT_W'(TOUT_BASE_CYC) << $past(clock_select_fuses_i)))
		else $error("delay does not follow fuses");

	a_supply_drop:
	assert property (s_supply_drop |-> core_reset_o && io_reset_o ##1
		state_ff == SRC_HOLD && core_reset_ff)
		else $error("supply drop not immediate");

	a_supply_level:
	assert property (lvl_s[LANE_SUPPLY] |=> core_reset_ff)
		else $error("supply-up source dropped while low");

	a_pin_width:
	assert property ($rose(pin_hit) |-> $past(lvl_s[LANE_PIN]) &&
		$past(lvl_s[LANE_PIN], 2))
		else $error("pin source without held low level");

	a_wdt_gate:
	assert property (wdt_src |-> wdt_enable_i && wdt_timeout_i)
		else $error("watchdog source without enable and time-out");

	a_wdt_pulse:
	assert property (s_wdt_fall |-> state_ff == SRC_HOLD ##1
		state_ff == SRC_STRETCH && cnt_ff == '0)
		else $error("watchdog count did not start after pulse");

	a_bod_gate:
	assert property (src_now.brownout |-> bod_enable_i && lvl_s[LANE_BOD])
		else $error("brown-out source while detector disabled");

	a_tp_follow:
	assert property ((lvl_s[LANE_TP] == src_now.testport) and
		(lvl_s[LANE_TP] |=> core_reset_ff))
		else $error("test-port source mismatch");

	a_restart_zero:
	assert property (s_restart |=> cnt_ff == '0 ##1 cnt_ff == '0)
		else $error("delay count not restarted");

	a_cause_por:
	assert property (src_now.supply_up |=> reset_cause_o.supply_up &&
		!reset_cause_o.pin && !reset_cause_o.watchdog &&
		!reset_cause_o.brownout && !reset_cause_o.testport)
		else $error("supply-up did not clear other flags");

	a_cause_set:
	assert property (src_now.pin |=> reset_cause_o.pin ||
		$past(src_now.supply_up))
		else $error("pin cause flag not set");

	a_vector_fetch:
	assert property (vector_fetch_o |-> !core_reset_ff && $past(core_reset_ff)
		##1 !vector_fetch_o)
		else $error("vector fetch not at release");

endmodule
`default_nettype wire

// ===== design/src_pkg.sv
// system reset controller: shared constants and types
// assumes a single 100 MHz system clock with synchronous active-low reset
package src_pkg;

	// system clock
	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 10;

	// minimum reset pin pulse width, 1.5 us held in ns
	localparam int T_RST_MIN_NS = 1500;
	localparam int RST_MIN_CYC =
		(T_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// stretch delay: base count shifted by the clock-select fuses
	localparam int FUSE_W = 4;
	localparam int CNT_W = 24;
	localparam int TOUT_BASE_CYC_DEF = 16;

	// synchroniser lanes and their values under reset
	localparam int SYNC_W = 4;
	localparam int LANE_SUPPLY = 0;
	localparam int LANE_PIN = 1;
	localparam int LANE_BOD = 2;
	localparam int LANE_TP = 3;
	localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 4'h3;

	// one bit per reset source, also the reset_cause_register layout
	typedef struct packed {
		logic testport;
		logic watchdog;
		logic brownout;
		logic pin;
		logic supply_up;
	} src_flags_t;

	localparam logic [4:0] FLAGS_RST = 5'h00;

	typedef enum logic [1:0] {
		SRC_HOLD,
		SRC_STRETCH,
		SRC_RUN
	} src_state_t;

endpackage

// ===== design/src_sync3.sv
// three-stage synchroniser with agreement filter
// assumes async_i changes with no relation to clk_i
`timescale 1ns/1ps
`default_nettype none
module src_sync3 import src_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// levels
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;

	// a lane moves only once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			q_ff <= RST_VAL;
		end else begin
			s1_ff <= async_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= (s2_ff & s3_ff) | (q_ff & (s2_ff ^ s3_ff));
		end
	end

	assign sync_o = q_ff;

endmodule
`default_nettype wire

// ===== design/src_persist.sv
// level persistence check: hit once a level has held more than N cycles
// assumes lvl_i is already in the clk_i domain
`timescale 1ns/1ps
`default_nettype none
module src_persist import src_pkg::*; #(
	parameter int N = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// level in, qualified level out
	input wire logic lvl_i,
	output logic hit_o
);

	localparam int CW = $clog2(N + 1);
	localparam logic [CW-1:0] N_C = CW'(N);

	logic [CW-1:0] cnt_ff;
	logic hit_ff;

	// saturating count of consecutive high cycles
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cnt_ff <= '0;
		end else if (!lvl_i) begin
			cnt_ff <= '0;
		end else if (cnt_ff != N_C) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			hit_ff <= 1'b0;
		end else begin
			hit_ff <= lvl_i && (cnt_ff == N_C);
		end
	end

	assign hit_o = hit_ff;

endmodule
`default_nettype wire

// ===== verif/src_far_model.sv
// far side of the reset controller: detectors, reset pin, watchdog, test port
// assumes the caller runs on clk_i; all changes land at the falling edge
`timescale 1ns/1ps
`default_nettype none
module src_far_model (
	// clock
	input wire logic clk_i,
	// source levels
	output var logic supply_low_o,
	output var logic reset_pin_n_o,
	output var logic bod_low_o,
	output var logic testport_rst_o,
	output var logic wdt_timeout_o
);
	initial begin
		supply_low_o = 1'b1;
		reset_pin_n_o = 1'b1;
		bod_low_o = 1'b0;
		testport_rst_o = 1'b0;
		wdt_timeout_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic set_supply(input logic v);
		@(negedge clk_i);
		supply_low_o = v;
	endtask
	task automatic set_bod(input logic v);
		@(negedge clk_i);
		bod_low_o = v;
	endtask
	task automatic set_tp(input logic v);
		@(negedge clk_i);
		testport_rst_o = v;
	endtask
	// pin has a pull-up, so release returns it high
	task automatic pin_low(input int n);
		@(negedge clk_i);
		reset_pin_n_o = 1'b0;
		hold(n);
		reset_pin_n_o = 1'b1;
	endtask
	// time-out lasts one cycle, as the watchdog gives it
	task automatic wdt_fire();
		@(negedge clk_i);
		wdt_timeout_o = 1'b1;
		@(negedge clk_i);
		wdt_timeout_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verif/system_reset_controller_test.sv
// self-checking bench for the reset controller
// assumes src_top with a stretch base of 2 cycles and the far-side model
`timescale 1ns/1ps
`default_nettype none
module system_reset_controller_test import src_pkg::*;;
	localparam int BASE = 2;
	logic clk_i, resetn_i, bod_en, wdt_en, sup, pin_n, bod, tp, wdt, wr;
	logic [FUSE_W-1:0] fuses;
	src_flags_t wdata, cause, act;
	logic io_rst, core_rst, vfetch;
	int err_total = 0;
	int compares = 0;
	int n0, n2, n;
	src_far_model u_far (.clk_i(clk_i), .supply_low_o(sup),
		.reset_pin_n_o(pin_n), .bod_low_o(bod), .testport_rst_o(tp),
		.wdt_timeout_o(wdt));
	src_top #(.TOUT_BASE_CYC(BASE)) u_dut (.clk_i(clk_i),
		.resetn_i(resetn_i), .supply_low_i(sup), .reset_pin_n_i(pin_n),
		.bod_enable_i(bod_en), .bod_low_i(bod), .testport_rst_i(tp),
		.wdt_enable_i(wdt_en), .wdt_timeout_i(wdt),
		.clock_select_fuses_i(fuses), .cause_wr_i(wr),
		.cause_wdata_i(wdata), .reset_cause_o(cause), .io_reset_o(io_rst),
		.core_reset_o(core_rst), .vector_fetch_o(vfetch),
		.src_active_o(act));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic fail(input string m);
		err_total++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		compares++;
		if (got !== exp)
			fail(m);
	endtask
	task automatic chk_f(input src_flags_t got, input src_flags_t exp);
		compares++;
		if (got !== exp)
			fail("cause flags");
	endtask
	task automatic chk_n(input int got, input int exp, input string m);
		compares++;
		if (got != exp)
			fail(m);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded: a stuck reset must not hang the run
	task automatic wait_rel(output int c);
		c = 0;
		while (core_rst !== 1'b0 && c < 3000) begin
			@(negedge clk_i);
			c++;
		end
		if (c >= 3000) begin
			fail("release timeout");
			final_report();
		end else begin
			chk(vfetch, 1'b1, "vector fetch");
		end
	endtask
	// one-cycle write strobe on the cause register
	task automatic wr_cause(input src_flags_t d);
		@(negedge clk_i);
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask
	task automatic clear();
		wr_cause(5'h00);
		@(negedge clk_i);
		chk_f(cause, 5'h00);
	endtask
	// one testport reset, returns cycles from drop to release
	task automatic tp_run(output int c);
		u_far.set_tp(1'b1);
		#1 chk(io_rst, 1'b1, "io reset not immediate");
		u_far.hold(5);
		chk(core_rst, 1'b1, "testport source");
		chk(act == 5'h10, 1'b1, "active testport");
		u_far.set_tp(1'b0);
		wait_rel(c);
	endtask
	initial begin
		resetn_i = 1'b0;
		bod_en = 1'b0;
		wdt_en = 1'b0;
		fuses = '0;
		wr = 1'b0;
		wdata = 5'h00;
		u_far.hold(2);
		resetn_i = 1'b1;
		chk(core_rst, 1'b1, "supply low");
		u_far.set_supply(1'b0);
		wait_rel(n);
		chk_f(cause, 5'h01);
		clear();
		$display("test power-up done");
		tp_run(n0);
		fuses = 4'h2;
		tp_run(n2);
		chk_n(n2 - n0, (BASE << 2) - BASE, "fuse delay");
		chk(n0 > BASE, 1'b1, "no stretch");
		chk_f(cause, 5'h10);
		u_far.set_tp(1'b1);
		u_far.hold(5);
		u_far.set_tp(1'b0);
		u_far.hold(6);
		chk(core_rst, 1'b1, "early release");
		tp_run(n);
		chk_n(n, n2, "restart");
		$display("test stretch done");
		clear();
		u_far.pin_low(100);
		u_far.hold(5);
		chk(core_rst, 1'b0, "short pin pulse");
		u_far.pin_low(160);
		chk(core_rst, 1'b1, "long pin pulse");
		wait_rel(n);
		chk_f(cause, 5'h02);
		$display("test pin done");
		clear();
		u_far.wdt_fire();
		u_far.hold(4);
		chk(core_rst, 1'b0, "watchdog off");
		wdt_en = 1'b1;
		u_far.wdt_fire();
		chk(core_rst, 1'b1, "watchdog");
		wait_rel(n);
		chk_f(cause, 5'h08);
		$display("test watchdog done");
		clear();
		u_far.set_bod(1'b1);
		u_far.hold(10);
		chk(core_rst, 1'b0, "brown-out off");
		bod_en = 1'b1;
		u_far.hold(1);
		chk(core_rst, 1'b1, "brown-out");
		u_far.set_bod(1'b0);
		wait_rel(n);
		chk_f(cause, 5'h04);
		u_far.set_supply(1'b1);
		u_far.hold(4);
		chk(core_rst, 1'b1, "supply drop");
		u_far.set_supply(1'b0);
		wait_rel(n);
		chk_f(cause, 5'h01);
		$display("test detectors done");
		tp_run(n);
		chk_f(cause, 5'h11);
		wr_cause(5'h10);
		@(negedge clk_i);
		chk_f(cause, 5'h10);
		u_far.set_tp(1'b1);
		u_far.hold(5);
		wr_cause(5'h00);
		chk_f(cause, 5'h10);
		u_far.set_tp(1'b0);
		wait_rel(n);
		$display("test cause done");
		final_report();
	end
endmodule
`default_nettype wire
